// *** logic/eetws_front_end.sv ***
// two-wire slave front end: address decode, acknowledge, protect gating
`timescale 1ns/1ns
`default_nettype none
module eetws_front_end
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic WRITE_PROTECT_IN,
    input wire logic SOFT_WRITE_LOCK_BIT_IN,
    input wire logic INFO_PAGE_FREEZE_IN,
    input wire logic BUSY_IN,
    input wire logic [7:0] READ_DATA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    output logic STANDBY_OUT,
    output logic WRITE_CYCLE_OUT,
    output logic DATA_VALID_OUT,
    output logic [7:0] DATA_OUT,
    output logic READ_REQ_OUT,
    output logic SPECIAL_OUT,
    output logic [1:0] SPACE_OUT,
    output logic [10:0] ADDR_OUT
);
    eetws_pkg::eetws_line_type line;
    eetws_pkg::eetws_state_type state;
    eetws_pkg::eetws_state_type next_state;
    eetws_pkg::eetws_target_type target;
    eetws_pkg::eetws_target_type next_target;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] tx;
    logic [7:0] next_tx;
    logic drive_low;
    logic next_drive_low;
    logic wrote;
    logic next_wrote;
    logic standby;
    logic next_standby;
    logic wcycle;
    logic next_wcycle;
    logic dvalid;
    logic next_dvalid;
    logic rreq;
    logic next_rreq;
    logic [7:0] dout;
    logic [7:0] next_dout;
    logic nacked;
    logic next_nacked;
    logic [7:0] full_byte;
    logic blocked;
    logic [1:0] protect_meta;
    logic [1:0] next_protect_meta;

    eetws_line_sync u_sync
    (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .scl_in(SCL_IN),
        .sda_in(SDA_IN),
        .line_out(line)
    );

    // --------------------------------------------------------------
    // write-protect pin synchroniser
    // --------------------------------------------------------------
    always_comb
    begin
        next_protect_meta = {protect_meta[0], WRITE_PROTECT_IN};
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            protect_meta <= 2'h0;
        end
        else
        begin
            protect_meta <= next_protect_meta;
        end
    end

    // --------------------------------------------------------------
    // protocol engine
    // --------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_target = target;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_tx = tx;
        next_drive_low = drive_low;
        next_wrote = wrote;
        next_standby = standby;
        next_wcycle = 1'b0;
        next_dvalid = 1'b0;
        next_rreq = 1'b0;
        next_dout = dout;
        next_nacked = nacked;
        full_byte = {shreg[6:0], line.sda};
        blocked = protect_meta[1] | SOFT_WRITE_LOCK_BIT_IN;
        if (line.start)
        begin
            next_state = eetws_pkg::EETWS_DEV;
            next_bit_cnt = eetws_pkg::EETWS_BIT_START;
            next_drive_low = 1'b0;
            next_wrote = 1'b0;
            next_standby = 1'b0;
        end
        else if (line.stop)
        begin
            next_state = eetws_pkg::EETWS_IDLE;
            next_drive_low = 1'b0;
            next_wcycle = wrote;
            next_standby = ~wrote;
            next_wrote = 1'b0;
        end
        else if (state == eetws_pkg::EETWS_IDLE)
        begin
            next_drive_low = 1'b0;
            if (!BUSY_IN && !wcycle)
            begin
                next_standby = 1'b1;
            end
        end
        else if (line.scl_rise)
        begin
            if (bit_cnt == eetws_pkg::EETWS_ACK_BIT)
            begin
                next_nacked = line.sda; // master ack on reads
            end
            else
            begin
                next_shreg = full_byte;
            end
        end
        else if (line.scl_fall)
        begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_drive_low = 1'b0;
            if (bit_cnt == eetws_pkg::EETWS_ACK_BIT)
            begin
                next_bit_cnt = eetws_pkg::EETWS_BIT_RESET;
                if (state == eetws_pkg::EETWS_RDATA)
                begin
                    if (nacked)
                    begin
                        next_state = eetws_pkg::EETWS_IDLE;
                    end
                    else
                    begin
                        next_tx = READ_DATA_IN;
                        next_rreq = 1'b1;
                        next_drive_low = ~READ_DATA_IN[7];
                    end
                end
            end
            else if (bit_cnt == eetws_pkg::EETWS_LAST_BIT)
            begin
                case (state)
                    eetws_pkg::EETWS_DEV:
                    begin
                        if (BUSY_IN
                            || (shreg[7:4] != eetws_pkg::EETWS_TYPE_ARRAY
                            && shreg[7:4] != eetws_pkg::EETWS_TYPE_SPECIAL))
                        begin
                            next_state = eetws_pkg::EETWS_IDLE;
                            next_standby = 1'b1;
                        end
                        else
                        begin
                            next_drive_low = 1'b1;
                            next_target.special = shreg[4];
                            next_target.addr[10:8] = shreg[3:1];
                            if (shreg[0])
                            begin
                                next_state = eetws_pkg::EETWS_RDATA;
                            end
                            else
                            begin
                                next_state = eetws_pkg::EETWS_WORD;
                            end
                        end
                    end
                    eetws_pkg::EETWS_WORD:
                    begin
                        next_drive_low = 1'b1;
                        next_target.addr[7:0] = shreg;
                        next_target.space = shreg[7:6];
                        if (target.special)
                        begin
                            next_target.addr[10:4] = 7'h00;
                        end
                        next_state = eetws_pkg::EETWS_WDATA;
                    end
                    eetws_pkg::EETWS_WDATA:
                    begin
                        next_dout = shreg;
                        if (!target.special)
                        begin
                            next_drive_low = ~blocked;
                        end
                        else
                        begin
                            case (target.space)
                                eetws_pkg::EETWS_SPC_INFO:
                                    next_drive_low = ~blocked
                                        & ~INFO_PAGE_FREEZE_IN;
                                eetws_pkg::EETWS_SPC_FREEZE:
                                    next_drive_low = ~blocked
                                        & ~INFO_PAGE_FREEZE_IN & shreg[1];
                                eetws_pkg::EETWS_SPC_SOFTLOCK:
                                    next_drive_low = ~protect_meta[1];
                                default:
                                    next_drive_low = 1'b0;
                            endcase
                        end
                        next_dvalid = next_drive_low;
                        next_wrote = next_drive_low;
                    end
                    default:
                    begin
                        next_drive_low = 1'b0;
                    end
                endcase
            end
            else if (state == eetws_pkg::EETWS_RDATA)
            begin
                next_tx = {tx[6:0], 1'b0};
                next_drive_low = ~tx[6];
            end
        end
        if (state == eetws_pkg::EETWS_RDATA && line.scl_fall
            && bit_cnt == eetws_pkg::EETWS_LAST_BIT)
        begin
            next_drive_low = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state <= eetws_pkg::EETWS_IDLE;
            target.space <= eetws_pkg::EETWS_SPC_INFO;
            target.special <= 1'b0;
            target.addr <= eetws_pkg::EETWS_ADDR_RESET;
            bit_cnt <= eetws_pkg::EETWS_BIT_RESET;
            shreg <= eetws_pkg::EETWS_BYTE_RESET;
            tx <= eetws_pkg::EETWS_BYTE_RESET;
            drive_low <= 1'b0;
            wrote <= 1'b0;
            standby <= 1'b1;
            wcycle <= 1'b0;
            dvalid <= 1'b0;
            rreq <= 1'b0;
            dout <= eetws_pkg::EETWS_BYTE_RESET;
            nacked <= 1'b0;
        end
        else
        begin
            state <= next_state;
            target <= next_target;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            tx <= next_tx;
            drive_low <= next_drive_low;
            wrote <= next_wrote;
            standby <= next_standby;
            wcycle <= next_wcycle;
            dvalid <= next_dvalid;
            rreq <= next_rreq;
            dout <= next_dout;
            nacked <= next_nacked;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    always_comb
    begin
        SDA_OUT = 1'b0;
        SDA_OE_N_OUT = ~drive_low;
        STANDBY_OUT = standby;
        WRITE_CYCLE_OUT = wcycle;
        DATA_VALID_OUT = dvalid;
        DATA_OUT = dout;
        READ_REQ_OUT = rreq;
        SPECIAL_OUT = target.special;
        SPACE_OUT = target.space;
        ADDR_OUT = target.addr;
    end
endmodule : eetws_front_end
`default_nettype wire

// *** logic/eetws_pkg.sv ***
// package of constants and types for the two-wire eeprom slave front end
// Notes on behaviour
// - sample sda on rising scl; change own sda only after falling scl
// - bytes go msb first, eight data clocks then a ninth acknowledge clock
// - any number of data bytes between start and stop
// - falling sda while scl high is start; start precedes every command
// - watch the lines always; ignore everything until a start
// - rising sda while scl high is stop and ends the communication
// - stop after a write launches the write cycle; others go standby
// - master releases sda in ninth clock; device holds it low to acknowledge
// - standby at power-up, after read stop, and when operations complete
// - while power-on reset holds, ignore commands; on release go standby
// - brown-out reset clears protocol state at once, no answers
// - write-protect pin high blocks array and info page writes
// - soft lock bit set blocks array and info page writes
// - first byte: 4-bit type, three address bits, direction bit
// - type 1010 selects the array, 1011 selects the special spaces
// - address byte bit 0: one reads, zero writes
// - acknowledge matching address byte; on mismatch no answer, standby
// - type 1010: address bits 3 to 1 give array bits 10 to 8
// - type 1011: freeze needs write, unique id needs read; select bits free
// - acknowledge word address; bits 7:6 decode the special space
// - protect pin high: address bytes acknowledged, write data bytes not
package eetws_pkg;
    localparam logic [3:0] EETWS_TYPE_ARRAY = 4'hA;
    localparam logic [3:0] EETWS_TYPE_SPECIAL = 4'hB;
    localparam logic [1:0] EETWS_SPC_INFO = 2'h0;
    localparam logic [1:0] EETWS_SPC_FREEZE = 2'h1;
    localparam logic [1:0] EETWS_SPC_UID = 2'h2;
    localparam logic [1:0] EETWS_SPC_SOFTLOCK = 2'h3;
    localparam logic [3:0] EETWS_ACK_BIT = 4'h8;
    localparam logic [3:0] EETWS_BIT_RESET = 4'h0;
    localparam logic [3:0] EETWS_BIT_START = 4'hF;
    localparam logic [3:0] EETWS_LAST_BIT = 4'h7;
    localparam logic [10:0] EETWS_ADDR_RESET = 11'h000;
    localparam logic [7:0] EETWS_BYTE_RESET = 8'h00;

    typedef enum logic [4:0]
    {
        EETWS_IDLE = 5'h01,
        EETWS_DEV = 5'h02,
        EETWS_WORD = 5'h04,
        EETWS_WDATA = 5'h08,
        EETWS_RDATA = 5'h10
    } eetws_state_type;

    typedef struct packed
    {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } eetws_line_type;

    typedef struct packed
    {
        logic [1:0] space;
        logic special;
        logic [10:0] addr;
    } eetws_target_type;
endpackage : eetws_pkg

// *** logic/eetws_line_sync.sv ***
// synchroniser and edge, start and stop detector for scl and sda
`timescale 1ns/1ns
`default_nettype none
module eetws_line_sync
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output var eetws_pkg::eetws_line_type line_out
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic scl_last;
    logic sda_last;
    eetws_pkg::eetws_line_type next_line;

    // --------------------------------------------------------------
    // edge and condition decode
    // --------------------------------------------------------------
    always_comb
    begin
        next_line.scl_rise = scl_meta[1] & ~scl_last;
        next_line.scl_fall = ~scl_meta[1] & scl_last;
        next_line.start = scl_meta[1] & scl_last & sda_last
            & ~sda_meta[1];
        next_line.stop = scl_meta[1] & scl_last & ~sda_last
            & sda_meta[1];
        next_line.sda = sda_meta[1];
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_last <= 1'b1;
            sda_last <= 1'b1;
            line_out <= '0;
        end
        else
        begin
            scl_meta <= {scl_meta[0], scl_in};
            sda_meta <= {sda_meta[0], sda_in};
            scl_last <= scl_meta[1];
            sda_last <= sda_meta[1];
            line_out <= next_line;
        end
    end
endmodule : eetws_line_sync
`default_nettype wire

// *** verif/eetws_front_end_sva.sv ***
// port checker for the two-wire eeprom slave front end
`timescale 1ns/1ns
`default_nettype none
module eetws_front_end_sva
(
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic WRITE_PROTECT_IN,
    input wire logic SOFT_WRITE_LOCK_BIT_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_N_OUT,
    input wire logic STANDBY_OUT,
    input wire logic WRITE_CYCLE_OUT,
    input wire logic DATA_VALID_OUT,
    input wire logic READ_REQ_OUT,
    input wire logic SPECIAL_OUT
);
    // ----------------------------------------
    // cycles since a stop on the raw lines
    // ----------------------------------------
    logic prev_sda;
    logic [3:0] since_stop, next_since_stop;
    always_comb
    begin
        next_since_stop = since_stop;
        if (SCL_IN && SDA_IN && !prev_sda)
            next_since_stop = 4'h0;
        else if (since_stop != 4'hF)
            next_since_stop = since_stop + 4'h1;
    end
    always_ff @(posedge REF_CLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            prev_sda <= 1'b1;
            since_stop <= 4'hF;
        end
        else
        begin
            prev_sda <= SDA_IN;
            since_stop <= next_since_stop;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    a_sda_value_zero: assert property (!SDA_OUT)
        else $error("sda drive value not zero");
    a_ack_drive_scl_low: assert property ($fell(SDA_OE_N_OUT) |-> !SCL_IN)
        else $error("sda drive began while scl high");
    a_ack_free_scl_low: assert property ($rose(SDA_OE_N_OUT) |-> !SCL_IN)
        else $error("sda drive ended while scl high");
    a_drive_stable_high: assert property (SCL_IN && $past(SCL_IN) |->
        $stable(SDA_OE_N_OUT))
        else $error("sda drive moved while scl high");
    a_standby_is_quiet: assert property (STANDBY_OUT |-> SDA_OE_N_OUT)
        else $error("sda driven in standby");
    a_write_after_stop: assert property (WRITE_CYCLE_OUT |-> since_stop <= 4'hA)
        else $error("write cycle without a stop");
    a_stop_ends_talk: assert property ((SCL_IN && $rose(SDA_IN)) |->
        ##[1:10] (STANDBY_OUT || WRITE_CYCLE_OUT))
        else $error("stop did not end communication");
    a_write_pulse_one: assert property (WRITE_CYCLE_OUT |=> !WRITE_CYCLE_OUT)
        else $error("write cycle pulse too long");
    a_valid_pulse_one: assert property (DATA_VALID_OUT |=> !DATA_VALID_OUT)
        else $error("data valid pulse too long");
    a_read_pulse_one: assert property (READ_REQ_OUT |=> !READ_REQ_OUT)
        else $error("read request pulse too long");
    a_protect_blocks: assert property ((WRITE_PROTECT_IN ||
        SOFT_WRITE_LOCK_BIT_IN) && !SPECIAL_OUT |-> !DATA_VALID_OUT)
        else $error("protected array byte accepted");
    c_write_cycle: cover property (WRITE_CYCLE_OUT);
    c_read_req: cover property (READ_REQ_OUT);
    c_ack_drive: cover property ($fell(SDA_OE_N_OUT));
    c_special: cover property (SPECIAL_OUT && DATA_VALID_OUT);
endmodule : eetws_front_end_sva
bind eetws_front_end eetws_front_end_sva u_eetws_front_end_sva
(
    .REF_CLK_IN(REF_CLK_IN),
    .RST_N_IN(RST_N_IN),
    .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN),
    .WRITE_PROTECT_IN(WRITE_PROTECT_IN),
    .SOFT_WRITE_LOCK_BIT_IN(SOFT_WRITE_LOCK_BIT_IN),
    .SDA_OUT(SDA_OUT),
    .SDA_OE_N_OUT(SDA_OE_N_OUT),
    .STANDBY_OUT(STANDBY_OUT),
    .WRITE_CYCLE_OUT(WRITE_CYCLE_OUT),
    .DATA_VALID_OUT(DATA_VALID_OUT),
    .READ_REQ_OUT(READ_REQ_OUT),
    .SPECIAL_OUT(SPECIAL_OUT)
);
`default_nettype wire

// *** verif/eetws_master_model.sv ***
// bus master model driving scl and the open-drain sda line
`timescale 1ns/1ns
`default_nettype none
module eetws_master_model
(
    input wire logic clk_in,
    input wire logic dev_oe_n_in,
    input wire logic dev_sda_in,
    output logic scl_out,
    output logic sda_out
);
    // ----------------------------------------
    // line and bit tasks
    // ----------------------------------------
    logic drive_sda = 1'b1;
    initial scl_out = 1'b1;
    // pulled-up wire, either party pulls low
    assign sda_out = drive_sda & (dev_oe_n_in | dev_sda_in);
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wait_n
    // sda moves only while scl low
    task automatic clk_bit(input logic b, output logic got);
        scl_out = 1'b0;
        wait_n(4);
        drive_sda = b;
        wait_n(4);
        scl_out = 1'b1;
        wait_n(4);
        got = sda_out;
        wait_n(4);
    endtask : clk_bit
    task automatic start();
        scl_out = 1'b0;
        wait_n(4);
        drive_sda = 1'b1;
        wait_n(4);
        scl_out = 1'b1;
        wait_n(4);
        drive_sda = 1'b0;
        wait_n(4);
    endtask : start
    task automatic stop();
        scl_out = 1'b0;
        wait_n(4);
        drive_sda = 1'b0;
        wait_n(4);
        scl_out = 1'b1;
        wait_n(4);
        drive_sda = 1'b1;
        wait_n(4);
    endtask : stop
    // msb first, then the ninth clock; mack 1 releases the line
    task automatic xfer(input logic [7:0] tx, input logic mack,
        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            clk_bit(tx[i], rx[i]);
        clk_bit(mack, ack);
    endtask : xfer
endmodule : eetws_master_model
`default_nettype wire

// *** verif/eetws_front_end_bench.sv ***
// self-checking bench of the two-wire eeprom slave front end
`timescale 1ns/1ns
`default_nettype none
module eetws_front_end_bench;
    // ----------------------------------------
    // harness
    // ----------------------------------------
    logic clk, rst_n, wp, lock, busy, scl, sda, sda_o, oe_n, stby;
    logic wcyc, dval, rreq, spec, ack, frz;
    logic [7:0] rdata, dout, rx;
    logic [1:0] space;
    logic [10:0] addr;
    int failures = 0;
    int check_count = 0;
    int n_wc = 0;
    int n_dv = 0;
    int n_rq = 0;
    eetws_front_end u_eetws_front_end (.REF_CLK_IN(clk), .RST_N_IN(rst_n),
        .SCL_IN(scl), .SDA_IN(sda), .WRITE_PROTECT_IN(wp),
        .SOFT_WRITE_LOCK_BIT_IN(lock), .INFO_PAGE_FREEZE_IN(frz),
        .BUSY_IN(busy), .READ_DATA_IN(rdata), .SDA_OUT(sda_o),
        .SDA_OE_N_OUT(oe_n), .STANDBY_OUT(stby), .WRITE_CYCLE_OUT(wcyc),
        .DATA_VALID_OUT(dval), .DATA_OUT(dout), .READ_REQ_OUT(rreq),
        .SPECIAL_OUT(spec), .SPACE_OUT(space), .ADDR_OUT(addr));
    eetws_master_model u_eetws_master_model (.clk_in(clk),
        .dev_oe_n_in(oe_n), .dev_sda_in(sda_o), .scl_out(scl),
        .sda_out(sda));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        n_wc += int'(wcyc === 1'b1);
        n_dv += int'(dval === 1'b1);
        n_rq += int'(rreq === 1'b1);
    end
    task automatic check_value(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check_value
    task automatic send(input logic [7:0] b, input logic exp, input string nm);
        u_eetws_master_model.xfer(b, 1'b1, rx, ack);
        check_value(nm, 16'(ack), 16'(exp));
    endtask : send
    task automatic settle();
        repeat (16) @(negedge clk);
    endtask : settle
    task automatic report_and_stop();
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        report_and_stop();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        wp = 1'b0;
        lock = 1'b0;
        busy = 1'b0;
        frz = 1'b0;
        rdata = 8'h96;
        settle();
        check_value("oe_n_rst", 16'(oe_n), 16'h0001);
        check_value("stby_rst", 16'(stby), 16'h0001);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        send(8'hA0, 1'b1, "no_start");
        u_eetws_master_model.start();
        send(8'hAA, 1'b0, "dev_wr");
        send(8'h35, 1'b0, "word");
        check_value("addr", 16'(addr), 16'h0535);
        send(8'h5A, 1'b0, "data0");
        check_value("dout", 16'(dout), 16'h005A);
        send(8'hC3, 1'b0, "data1");
        u_eetws_master_model.stop();
        settle();
        check_value("n_wc", 16'(n_wc), 16'h0001);
        check_value("n_dv", 16'(n_dv), 16'h0002);
        for (int i = 0; i < 2; i++)
        begin
            wp = (i == 0);
            lock = (i == 1);
            u_eetws_master_model.start();
            send(8'hA0, 1'b0, "dev_prot");
            send(8'h10, 1'b0, "word_prot");
            send(8'h77, 1'b1, "data_prot");
            u_eetws_master_model.stop();
        end
        wp = 1'b0;
        lock = 1'b0;
        settle();
        check_value("n_wc_prot", 16'(n_wc), 16'h0001);
        u_eetws_master_model.start();
        send(8'hA1, 1'b0, "dev_rd");
        u_eetws_master_model.xfer(8'hFF, 1'b0, rx, ack);
        check_value("rd0", 16'(rx), 16'h0096);
        rdata = 8'h3C;
        u_eetws_master_model.xfer(8'hFF, 1'b1, rx, ack);
        check_value("rd1", 16'(rx), 16'h003C);
        u_eetws_master_model.stop();
        settle();
        check_value("n_rq", 16'(n_rq), 16'h0002);
        check_value("stby_rd", 16'(stby), 16'h0001);
        for (int s = 0; s < 5; s++)
        begin
            frz = (s == 4);
            u_eetws_master_model.start();
            send(8'hBE, 1'b0, "dev_spc");
            send({s[1:0], 6'h05}, 1'b0, "word_spc");
            check_value("spec", 16'(spec), 16'h0001);
            check_value("space", 16'(space), 16'(s[1:0]));
            check_value("addr_spc", 16'(addr), 16'h0005);
            send(8'h02, (s == 2) || (s == 4), "data_spc");
            u_eetws_master_model.stop();
        end
        frz = 1'b0;
        check_value("n_dv_spc", 16'(n_dv), 16'h0005);
        for (int i = 0; i < 2; i++)
        begin
            busy = (i == 1);
            u_eetws_master_model.start();
            send((i == 1) ? 8'hA0 : 8'h90, 1'b1, "dev_nack");
            u_eetws_master_model.stop();
            settle();
            check_value("stby_nack", 16'(stby), 16'h0001);
        end
        busy = 1'b0;
        u_eetws_master_model.start();
        send(8'hA0, 1'b0, "dev_int");
        u_eetws_master_model.start();
        repeat (9) u_eetws_master_model.clk_bit(1'b1, ack);
        u_eetws_master_model.start();
        u_eetws_master_model.stop();
        settle();
        check_value("stby_rec", 16'(stby), 16'h0001);
        u_eetws_master_model.start();
        send(8'hA0, 1'b0, "dev_bor");
        rst_n = 1'b0;
        @(negedge clk);
        check_value("oe_n_bor", 16'(oe_n), 16'h0001);
        check_value("stby_bor", 16'(stby), 16'h0001);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        u_eetws_master_model.stop();
        u_eetws_master_model.start();
        send(8'hA0, 1'b0, "dev_after");
        u_eetws_master_model.stop();
        settle();
        check_value("n_wc_end", 16'(n_wc), 16'h0004);
        report_and_stop();
    end
endmodule : eetws_front_end_bench
`default_nettype wire
